// [logic/vpic_cfg.svh]
`ifndef VPIC_CFG_SVH
`define VPIC_CFG_SVH

// register offsets on the plain register port
`define VPIC_ADDR_EN0     8'ha8
`define VPIC_ADDR_EN1     8'ha9
`define VPIC_ADDR_EN2     8'haa
`define VPIC_ADDR_EN3     8'hab
`define VPIC_ADDR_EN4     8'hac
`define VPIC_ADDR_EN5     8'had
`define VPIC_ADDR_LVL_LO  8'hb8
`define VPIC_ADDR_LVL_HI  8'hf8
`define VPIC_ADDR_EFLAG   8'ha4
`define VPIC_ADDR_ETYPE   8'ha5
`define VPIC_ADDR_EPOL    8'ha6
`define VPIC_ADDR_EBOTH   8'ha7
`define VPIC_ADDR_EENAB   8'ha3
`define VPIC_ADDR_PEND0   8'he0
`define VPIC_ADDR_PEND1   8'he1
`define VPIC_ADDR_PEND2   8'he2
`define VPIC_ADDR_PEND3   8'he3
`define VPIC_ADDR_INSVC   8'he4

// field positions and reset values
`define VPIC_GLOBAL_EN_BIT 7
`define VPIC_RESET_BYTE    8'h00

// vector layout: base 0003h, stride 8
`define VPIC_VEC_BASE      8'h03
`define VPIC_RESET_VEC     16'h0000

// latency from instruction end to routine start, machine cycles
`define VPIC_LAT_MIN       5
`define VPIC_LAT_MAX       8

`endif

// [logic/vpic_pkg.sv]
package vpic_pkg;
  typedef logic [1:0] vpic_level_t;
  typedef logic [4:0] vpic_src_t;
  typedef enum logic [2:0] {
    VPIC_IDLE  = 3'b001,
    VPIC_FIXED = 3'b010,
    VPIC_CALL  = 3'b100
  } vpic_state_t;
endpackage

// [logic/vpic_ctrl.sv]
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "vpic_cfg.svh"
// How it works
// - thirty-two sources, each with fixed vector and fixed default rank
// - core long-calls vector 0003h plus eight times source number
// - service needs global enable and the source's own enable
// - request flag set on arrival, cleared by hardware on acceptance
// - latched request pending until accepted, reset or software clear
// - sampling and acceptance only in last instruction cycle
// - instruction end to routine start takes five to eight machine cycles
// - interrupt return restores pc and releases in-service level
// - higher group level wins among simultaneous requests
// - equal levels resolved by source number polling order
// - winning source's low vector byte fixed at sampling
// - eight groups of four, group g holds g, g+8, g+16, g+24
// - level three highest, level zero lowest
// - levels reset to zero, higher level number outranks lower
// - external pins have trigger type, polarity and enable per pin
// - readable per-pin event flags
// - global enable is bit seven of first enable register
// - trigger type zero level, one edge, reset level
// - pin flag set on condition, cleared on service or write zero
// - dual-edge bit makes pin request on both edges, reset off
module vpic_ctrl (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // register port
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [7:0]           reg_rdata_o,
  // request sources
  input  wire logic [31:0]          src_req_i,
  input  wire logic [7:0]           ext_pin_i,
  // core sequencer
  input  wire logic                 last_cycle_i,
  input  wire logic                 irq_ack_i,
  input  wire logic                 irq_return_i,
  input  wire logic                 reset_entry_i,
  output logic                      irq_pending_o,
  output logic      [7:0]           vector_target_o,
  output vpic_pkg::vpic_src_t       vector_src_o,
  output logic                      reset_entry_o
);
  import vpic_pkg::*;

  // external pin numbers map onto these source slots
  localparam int EXT_SRC [8] = '{0, 1, 2, 3, 28, 29, 30, 31};

  // software registers
  logic [7:0]  irq_enable_reg0;
  logic [7:0]  irq_enable_reg1;
  logic [7:0]  irq_enable_reg2;
  logic [7:0]  irq_enable_reg3;
  logic [7:0]  irq_enable_reg4;
  logic [7:0]  irq_enable_reg5;
  logic [7:0]  group_level_low_bits;
  logic [7:0]  group_level_high_bits;
  logic [7:0]  pin_trigger_type_sel;
  logic [7:0]  pin_polarity_sel;
  logic [7:0]  pin_event_flags;
  logic [7:0]  pin_dual_edge_enable;
  logic [7:0]  pin_request_enable;
  // core state
  logic [31:0] pend;
  logic [3:0]  in_service;
  logic [7:0]  pin_last;
  logic [31:0] src_en;
  logic [31:0] req_raw;
  logic [31:0] eligible;
  logic [7:0]  pin_hit;
  logic        global_irq_enable;
  logic        win_valid;
  vpic_src_t   win_src;
  vpic_level_t win_lvl;
  vpic_state_t state;
  vpic_state_t next_state;
  logic        take;
  logic        wr_hit_flag;
  logic [2:0]  svc_top;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // level of the group that owns a source
  function automatic vpic_level_t src_level(input vpic_src_t s, input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [2:0] g;
    g = s[2:0];
    return {hi[g], lo[g]};
  endfunction

  // highest level currently in service, or -1 encoded as valid=0
  function automatic logic [2:0] top_level(input logic [3:0] v);
    logic [2:0] r;
    r = 3'b000;
    for (int i = 0; i < 4; i++) begin
      if (v[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  assign global_irq_enable = irq_enable_reg0[`VPIC_GLOBAL_EN_BIT];
  assign src_en = {irq_enable_reg5[1:0], irq_enable_reg4[5:0], irq_enable_reg3[5:0],
                   irq_enable_reg2[5:0], irq_enable_reg1[5:0], irq_enable_reg0[5:0]};
  // top in-service level, needed by the return release
  assign svc_top = top_level(in_service);

  ////////////////////////////////////////////////////////////////////////
  // external pin detection
  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : g_pin
      logic rise;
      logic fall;
      logic lvl;
      assign rise = ext_pin_i[p] & ~pin_last[p];
      assign fall = ~ext_pin_i[p] & pin_last[p];
      assign lvl  = ext_pin_i[p] ~^ pin_polarity_sel[p];  // polarity 1 = high level
      // level when type 0, edge when type 1; dual edge overrides type and polarity
      assign pin_hit[p] = pin_request_enable[p] & (
        pin_dual_edge_enable[p] ? (rise | fall) :
        pin_trigger_type_sel[p] ? (pin_polarity_sel[p] ? rise : fall) : lvl);
    end
  endgenerate

  // previous pin sample for edge detection
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_last <= `VPIC_RESET_BYTE;
    end else begin
      pin_last <= ext_pin_i;
    end
  end

  // raw request per source; pins drive their slot directly from pin_hit, not through the flag
  always_comb begin
    req_raw = src_req_i;
    for (int i = 0; i < 8; i++) begin
      req_raw[EXT_SRC[i]] = src_req_i[EXT_SRC[i]] | pin_hit[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration

  // scan all sources; higher level wins, then lower number
  always_comb begin
    logic [2:0] cur;
    cur       = top_level(in_service);
    eligible  = pend & src_en & {32{global_irq_enable}};
    win_valid = 1'b0;
    win_src   = 5'h00;
    win_lvl   = 2'b00;
    for (int i = 31; i >= 0; i--) begin
      // descending scan with >= lets the lower number win ties
      if (eligible[i] &&
          (!cur[2] || src_level(5'(i), group_level_low_bits,
                                group_level_high_bits) > cur[1:0]) &&
          (!win_valid || src_level(5'(i), group_level_low_bits,
                                   group_level_high_bits) >= win_lvl)) begin
        win_valid = 1'b1;
        win_src   = 5'(i);
        win_lvl   = src_level(5'(i), group_level_low_bits, group_level_high_bits);
      end
    end
  end

  // sample only in last instruction cycle
  assign take = (state == VPIC_IDLE) & last_cycle_i & win_valid & ~reset_entry_i;

  ////////////////////////////////////////////////////////////////////////
  // acceptance sequence: idle, vector fixed, back to idle on the acknowledge
  always_comb begin
    next_state = state;
    case (state)
      VPIC_IDLE: begin
        if (take) begin
          next_state = VPIC_FIXED;
        end
      end
      VPIC_FIXED: begin
        if (irq_ack_i) begin
          next_state = VPIC_IDLE;
        end
      end
      default: begin
        next_state = VPIC_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= VPIC_IDLE;
    end else if (reset_entry_i) begin
      state <= VPIC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // vector byte captured at sampling so later arrivals cannot move it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vector_target_o <= `VPIC_RESET_BYTE;
      vector_src_o    <= 5'h00;
    end else if (reset_entry_i) begin
      vector_target_o <= 8'(`VPIC_RESET_VEC);
      vector_src_o    <= 5'h00;
    end else if (take) begin
      vector_target_o <= {win_src, 3'b000} + `VPIC_VEC_BASE;
      vector_src_o    <= win_src;
    end
  end

  // offered from the sample until the acknowledge
  assign irq_pending_o = (state == VPIC_FIXED);
  assign reset_entry_o = reset_entry_i;

  ////////////////////////////////////////////////////////////////////////
  // pending latches; arrival beats the acceptance clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (req_raw[i]) begin
          pend[i] <= 1'b1;
        end else if (state == VPIC_FIXED && irq_ack_i && vector_src_o == 5'(i)) begin
          pend[i] <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == (`VPIC_ADDR_PEND0 + 8'(i / 8)) &&
                     !reg_wdata_i[i % 8]) begin
          pend[i] <= 1'b0;
        end
      end
    end
  end

  // in-service levels: set on acknowledge, top one released on return
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_service <= 4'h0;
    end else begin
      if (irq_return_i && svc_top[2]) begin
        in_service[svc_top[1:0]] <= 1'b0;
      end
      if (state == VPIC_FIXED && irq_ack_i) begin
        in_service[src_level(vector_src_o, group_level_low_bits,
                             group_level_high_bits)] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin event flags; a new event wins over service or software clear
  assign wr_hit_flag = reg_wr_i && reg_addr_i == `VPIC_ADDR_EFLAG;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_event_flags <= `VPIC_RESET_BYTE;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pin_hit[i]) begin
          pin_event_flags[i] <= 1'b1;
        end else if (state == VPIC_FIXED && irq_ack_i && vector_src_o == 5'(EXT_SRC[i])) begin
          pin_event_flags[i] <= 1'b0;
        end else if (wr_hit_flag && !reg_wdata_i[i]) begin
          pin_event_flags[i] <= 1'b0;
        end
      end
    end
  end

  // plain read/write configuration registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_enable_reg0       <= `VPIC_RESET_BYTE;
      irq_enable_reg1       <= `VPIC_RESET_BYTE;
      irq_enable_reg2       <= `VPIC_RESET_BYTE;
      irq_enable_reg3       <= `VPIC_RESET_BYTE;
      irq_enable_reg4       <= `VPIC_RESET_BYTE;
      irq_enable_reg5       <= `VPIC_RESET_BYTE;
      group_level_low_bits  <= `VPIC_RESET_BYTE;
      group_level_high_bits <= `VPIC_RESET_BYTE;
      pin_trigger_type_sel  <= `VPIC_RESET_BYTE;
      pin_polarity_sel      <= `VPIC_RESET_BYTE;
      pin_dual_edge_enable  <= `VPIC_RESET_BYTE;
      pin_request_enable    <= `VPIC_RESET_BYTE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `VPIC_ADDR_EN0:    irq_enable_reg0       <= reg_wdata_i & 8'hbf;
        `VPIC_ADDR_EN1:    irq_enable_reg1       <= reg_wdata_i & 8'h3f;
        `VPIC_ADDR_EN2:    irq_enable_reg2       <= reg_wdata_i & 8'h3f;
        `VPIC_ADDR_EN3:    irq_enable_reg3       <= reg_wdata_i & 8'h3f;
        `VPIC_ADDR_EN4:    irq_enable_reg4       <= reg_wdata_i & 8'h3f;
        `VPIC_ADDR_EN5:    irq_enable_reg5       <= reg_wdata_i & 8'h03;
        `VPIC_ADDR_LVL_LO: group_level_low_bits  <= reg_wdata_i;
        `VPIC_ADDR_LVL_HI: group_level_high_bits <= reg_wdata_i;
        `VPIC_ADDR_ETYPE:  pin_trigger_type_sel  <= reg_wdata_i;
        `VPIC_ADDR_EPOL:   pin_polarity_sel      <= reg_wdata_i;
        `VPIC_ADDR_EBOTH:  pin_dual_edge_enable  <= reg_wdata_i;
        `VPIC_ADDR_EENAB:  pin_request_enable    <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `VPIC_ADDR_EN0:    reg_rdata_o <= irq_enable_reg0;
        `VPIC_ADDR_EN1:    reg_rdata_o <= irq_enable_reg1;
        `VPIC_ADDR_EN2:    reg_rdata_o <= irq_enable_reg2;
        `VPIC_ADDR_EN3:    reg_rdata_o <= irq_enable_reg3;
        `VPIC_ADDR_EN4:    reg_rdata_o <= irq_enable_reg4;
        `VPIC_ADDR_EN5:    reg_rdata_o <= irq_enable_reg5;
        `VPIC_ADDR_LVL_LO: reg_rdata_o <= group_level_low_bits;
        `VPIC_ADDR_LVL_HI: reg_rdata_o <= group_level_high_bits;
        `VPIC_ADDR_EFLAG:  reg_rdata_o <= pin_event_flags;
        `VPIC_ADDR_ETYPE:  reg_rdata_o <= pin_trigger_type_sel;
        `VPIC_ADDR_EPOL:   reg_rdata_o <= pin_polarity_sel;
        `VPIC_ADDR_EBOTH:  reg_rdata_o <= pin_dual_edge_enable;
        `VPIC_ADDR_EENAB:  reg_rdata_o <= pin_request_enable;
        `VPIC_ADDR_PEND0:  reg_rdata_o <= pend[7:0];
        `VPIC_ADDR_PEND1:  reg_rdata_o <= pend[15:8];
        `VPIC_ADDR_PEND2:  reg_rdata_o <= pend[23:16];
        `VPIC_ADDR_PEND3:  reg_rdata_o <= pend[31:24];
        `VPIC_ADDR_INSVC:  reg_rdata_o <= {4'h0, in_service};
        default:           reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end
endmodule

// [verification/vpic_core_model.sv]
`timescale 1ns/10ps
// behavioural core sequencer: four-cycle instruction slots
module vpic_core_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // slot control and handshake
  input  wire logic run_i,
  input  wire logic irq_pending_i,
  output logic      last_cycle_o,
  output logic      irq_ack_o
);
  logic [1:0] slot_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // last cycle pulses once a slot; quiet while halted so no sampling happens
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_cnt     <= 2'h0;
      last_cycle_o <= 1'b0;
    end else begin
      slot_cnt     <= slot_cnt + 2'h1;
      last_cycle_o <= run_i && (slot_cnt == 2'h2);
    end
  end

  // acknowledge in the first cycle after the vector is offered
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_ack_o <= 1'b0;
    end else begin
      irq_ack_o <= irq_pending_i && !irq_ack_o;
    end
  end
endmodule

// [verification/vpic_ctrl_assertions.sv]
`timescale 1ns/10ps
module vpic_ctrl_chk
  import vpic_pkg::*;
(
  // clock and reset
  input wire logic      clk_i,
  input wire logic      reset_n_i,
  // register port
  input wire logic      reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // core sequencer
  input wire logic      last_cycle_i,
  input wire logic      irq_ack_i,
  input wire logic      reset_entry_i,
  input wire logic      irq_pending_o,
  input wire logic [7:0] vector_target_o,
  input wire vpic_src_t vector_src_o,
  input wire logic      reset_entry_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // offer steps of the interrupt sequence
  sequence s_offer_rise;
    !irq_pending_o ##1 irq_pending_o;
  endsequence
  sequence s_ack_step;
    irq_pending_o && irq_ack_i && !reset_entry_i;
  endsequence

  a_take_last_cycle: assert property (s_offer_rise |-> $past(last_cycle_i))
    else $error("vector offered without a last cycle");
  a_ack_clears: assert property (s_ack_step |=> !irq_pending_o)
    else $error("offer still up after acknowledge");
  a_offer_holds: assert property (
    irq_pending_o && !irq_ack_i && !reset_entry_i |=> irq_pending_o)
    else $error("offer dropped without acknowledge");
  a_vec_format: assert property (
    irq_pending_o |-> vector_target_o == {vector_src_o, 3'h3})
    else $error("vector byte does not match source");
  a_vec_holds: assert property (
    !last_cycle_i && !reset_entry_i |=> $stable(vector_src_o))
    else $error("vector source changed outside a take");
  a_entry_copy: assert property (reset_entry_o == reset_entry_i)
    else $error("reset entry output differs from input");
  a_entry_aborts: assert property (reset_entry_i |=> !irq_pending_o)
    else $error("offer survived reset entry");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
endmodule

bind vpic_ctrl vpic_ctrl_chk u_vpic_ctrl_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .last_cycle_i(last_cycle_i), .irq_ack_i(irq_ack_i), .reset_entry_i(reset_entry_i),
  .irq_pending_o(irq_pending_o), .vector_target_o(vector_target_o),
  .vector_src_o(vector_src_o), .reset_entry_o(reset_entry_o)
);

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import vpic_pkg::*;
  logic        clk_i;
  logic        reset_n_i;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic [31:0] src_req_i;
  logic [7:0]  ext_pin_i;
  logic        last_cycle_i;
  logic        irq_ack_i;
  logic        irq_return_i;
  logic        reset_entry_i;
  logic        irq_pending_o;
  logic [7:0]  vector_target_o;
  vpic_src_t   vector_src_o;
  logic        reset_entry_o;
  logic        run;
  int          err_count;
  int          compares;
  logic [7:0]  addrs [15];
  logic [7:0]  masks [15];

  vpic_ctrl u_vpic_ctrl (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .src_req_i(src_req_i), .ext_pin_i(ext_pin_i),
    .last_cycle_i(last_cycle_i), .irq_ack_i(irq_ack_i), .irq_return_i(irq_return_i),
    .reset_entry_i(reset_entry_i), .irq_pending_o(irq_pending_o),
    .vector_target_o(vector_target_o), .vector_src_o(vector_src_o),
    .reset_entry_o(reset_entry_o)
  );
  vpic_core_model u_vpic_core_model (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .run_i(run), .irq_pending_i(irq_pending_o),
    .last_cycle_o(last_cycle_i), .irq_ack_o(irq_ack_i)
  );

  // 125 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // strobes drop before the next access, so no signal is driven twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
    @(posedge clk_i);
  endtask
  task automatic wait_pend(input logic v);
    repeat (60) begin
      #1;
      if (irq_pending_o === v) return;
      @(posedge clk_i);
    end
    chk(irq_pending_o, v);
    finish_test();
  endtask
  task automatic ret();
    irq_return_i <= 1'b1;
    @(posedge clk_i);
    irq_return_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // a is the expected winner, b is served only after the return
  task automatic race(input int a, input int b, input logic [7:0] lo, input logic [7:0] hi);
    wr(8'hb8, lo);
    wr(8'hf8, hi);
    src_req_i <= (32'h1 << a) | (32'h1 << b);
    @(posedge clk_i);
    src_req_i <= 32'h0;
    run <= 1'b1;
    wait_pend(1'b1);
    chk(vector_src_o, 8'(a));
    chk(vector_target_o, 8'(3 + 8 * a));
    wait_pend(1'b0);
    repeat (12) @(posedge clk_i);
    #1 chk(irq_pending_o, 1'b0);
    ret();
    wait_pend(1'b1);
    chk(vector_src_o, 8'(b));
    wait_pend(1'b0);
    run <= 1'b0;
    ret();
    $display("test race %0d over %0d done", a, b);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    src_req_i = 32'h0;
    ext_pin_i = 8'hff;
    irq_return_i = 1'b0;
    reset_entry_i = 1'b0;
    run = 1'b0;
    err_count = 0;
    compares = 0;
    addrs = '{8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had, 8'hb8, 8'hf8,
              8'ha3, 8'ha5, 8'ha6, 8'ha7, 8'ha4, 8'he0, 8'he4};
    masks = '{8'hbf, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h03, 8'hff, 8'hff,
              8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    // reset values, writable bits, unmapped place
    for (int i = 0; i < 15; i++) begin
      rd(addrs[i], 8'h00);
      wr(addrs[i], 8'hff);
      rd(addrs[i], masks[i]);
    end
    rd(8'h10, 8'h00);
    $display("test registers done");
    // global enable off: request latches but is never offered
    wr(8'ha8, 8'h3f);
    src_req_i <= 32'h20;
    @(posedge clk_i);
    src_req_i <= 32'h0;
    run <= 1'b1;
    repeat (16) @(posedge clk_i);
    #1 chk(irq_pending_o, 1'b0);
    rd(8'he0, 8'h20);
    run <= 1'b0;
    wr(8'ha8, 8'hbf);
    repeat (12) @(posedge clk_i);
    #1 chk(irq_pending_o, 1'b0);
    run <= 1'b1;
    wait_pend(1'b1);
    chk(vector_target_o, 8'h2b);
    wait_pend(1'b0);
    run <= 1'b0;
    rd(8'he0, 8'h00);
    ret();
    $display("test gating done");
    race(4, 12, 8'h00, 8'h00);
    race(6, 5, 8'h40, 8'h40);
    race(6, 5, 8'h40, 8'h00);
    race(13, 21, 8'h20, 8'h20);
    race(7, 24, 8'h00, 8'h80);
    // pins: 0 low level, 7 rising edge, 6 rising with dual edge
    wr(8'ha3, 8'hc1);
    wr(8'ha5, 8'hc0);
    wr(8'ha6, 8'hc0);
    wr(8'ha7, 8'h40);
    ext_pin_i <= 8'hbe;
    @(posedge clk_i);
    ext_pin_i <= 8'h3e;
    @(posedge clk_i);
    rd(8'ha4, 8'h41);
    ext_pin_i <= 8'hfe;
    @(posedge clk_i);
    ext_pin_i <= 8'hff;
    @(posedge clk_i);
    rd(8'ha4, 8'hc1);
    rd(8'he3, 8'hc0);
    wr(8'ha4, 8'hbe);
    rd(8'ha4, 8'h80);
    wr(8'he3, 8'h80);
    wr(8'he0, 8'h00);
    rd(8'he0, 8'h00);
    run <= 1'b1;
    wait_pend(1'b1);
    chk(vector_target_o, 8'hfb);
    wait_pend(1'b0);
    rd(8'ha4, 8'h00);
    run <= 1'b0;
    ret();
    $display("test pins done");
    // nesting: the routine opens only a higher source, a masked one stays latched
    src_req_i <= 32'h10;
    @(posedge clk_i);
    src_req_i <= 32'h0;
    run <= 1'b1;
    wait_pend(1'b1);
    chk(vector_src_o, 8'h04);
    wait_pend(1'b0);
    wr(8'ha8, 8'h80);
    wr(8'ha9, 8'h02);
    src_req_i <= 32'ha0;
    @(posedge clk_i);
    src_req_i <= 32'h0;
    wait_pend(1'b1);
    chk(vector_src_o, 8'h07);
    chk(vector_target_o, 8'h3b);
    wait_pend(1'b0);
    rd(8'he4, 8'h05);
    ret();
    rd(8'he4, 8'h01);
    ret();
    // enable byte 1 first, so the byte 0 write, setting source 5's own enable bit, is the one that frees it
    wr(8'ha9, 8'h3f);
    wr(8'ha8, 8'hbf);
    wait_pend(1'b1);
    chk(vector_src_o, 8'h05);
    wait_pend(1'b0);
    run <= 1'b0;
    ret();
    $display("test nesting done");
    // reset entry aborts an offered vector
    src_req_i <= 32'h10;
    @(posedge clk_i);
    src_req_i <= 32'h0;
    run <= 1'b1;
    wait_pend(1'b1);
    reset_entry_i <= 1'b1;
    @(posedge clk_i);
    #1 chk(reset_entry_o, 1'b1);
    chk(irq_pending_o, 1'b0);
    chk(vector_target_o, 8'h00);
    reset_entry_i <= 1'b0;
    run <= 1'b0;
    $display("test reset entry done");
    // reset in mid-run clears latches, levels and enables
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    src_req_i <= 32'h8;
    repeat (3) @(posedge clk_i);
    src_req_i <= 32'h0;
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(8'he0, 8'h00);
    rd(8'hf8, 8'h00);
    rd(8'he4, 8'h00);
    rd(8'ha8, 8'h00);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
